// ---- logic/host_link_if.sv ----
// Link between the command decoder and one indirect host context
`timescale 1ns/1ns
interface host_link_if;
	logic ctl_wr;
	logic [15:0] ctl_data;
	logic poke;
	logic blk_step;
	logic blk_abort;
	logic [8:0] ptr;
	logic [4:0] page;
	logic poke_ok;
	logic [8:0] blk_idx;
	logic [15:0] status;
	modport core(output ctl_wr, ctl_data, poke, blk_step, blk_abort,
		input ptr, page, poke_ok, blk_idx, status);
	modport host(input ctl_wr, ctl_data, poke, blk_step, blk_abort,
		output ptr, page, poke_ok, blk_idx, status);
endinterface

// ---- logic/indirect_host.sv ----
// Cached pointer, page, write enable and status of one indirect host
`timescale 1ns/1ns
module indirect_host import regbank_pkg::*; (
	input wire logic clk,
	input wire logic nrst,
	host_link_if.host link
);
	logic [8:0] ptr_reg, ptr_next;
	logic [4:0] page_reg, page_next;
	logic en_reg, en_next;
	logic fail_reg, fail_next;
	logic blkfail_reg, blkfail_next;
	logic [8:0] idx_reg, idx_next;
	logic [8:0] wr_ptr;
	logic [4:0] wr_page;

	assign wr_ptr = link.ctl_data[CTL_PTR_MSB:0];
	assign wr_page = link.ctl_data[CTL_PAGE_MSB:CTL_PAGE_LSB];

	always_comb begin
		ptr_next = ptr_reg;
		page_next = page_reg;
		en_next = en_reg;
		fail_next = fail_reg;
		blkfail_next = blkfail_reg;
		idx_next = idx_reg;
		if (link.ctl_wr) begin
			if (wr_ptr == PTR_POKE_SWITCH && wr_page == PAGE_POKE_ON) begin
				en_next = 1'b1;
			end else if (wr_ptr == PTR_POKE_SWITCH && wr_page == PAGE_POKE_OFF) begin
				en_next = 1'b0;
			end else begin
				// Out-of-range pages are cached; the poke check rejects them
				ptr_next = wr_ptr;
				page_next = wr_page;
				idx_next = 9'h000;
				if (wr_ptr == PTR_BLOCK) begin
					blkfail_next = 1'b0;
				end
			end
		end
		if (link.poke) begin
			fail_next = !link.poke_ok;
		end
		if (link.blk_step && idx_reg != 9'h1ff) begin
			idx_next = 9'(idx_reg + 9'h001);
		end
		// Abort sets even when a new block read is requested the same cycle
		if (link.blk_abort && ptr_reg == PTR_BLOCK) begin
			blkfail_next = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ptr_reg <= 9'h000;
			page_reg <= 5'h00;
			en_reg <= 1'b0;
			fail_reg <= 1'b0;
			blkfail_reg <= 1'b0;
			idx_reg <= 9'h000;
		end else begin
			ptr_reg <= ptr_next;
			page_reg <= page_next;
			en_reg <= en_next;
			fail_reg <= fail_next;
			blkfail_reg <= blkfail_next;
			idx_reg <= idx_next;
		end
	end

	assign link.ptr = ptr_reg;
	assign link.page = page_reg;
	assign link.poke_ok = en_reg && page_reg <= LAST_PAGE;
	assign link.blk_idx = idx_reg;
	assign link.status = {14'h0000, fail_reg, blkfail_reg};

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_page_cached;
		@(posedge clk) disable iff (!nrst)
		link.ctl_wr && wr_ptr != PTR_POKE_SWITCH |=> page_reg == $past(wr_page);
	endproperty
	a_page_cached: assert property (p_page_cached) else $error("page not cached");

	property p_pointer_cached;
		@(posedge clk) disable iff (!nrst)
		link.ctl_wr && wr_ptr != PTR_POKE_SWITCH ##1 !link.ctl_wr |=> link.ptr == $past(wr_ptr, 2);
	endproperty
	a_pointer_cached: assert property (p_pointer_cached) else $error("pointer lost");

	property p_poke_switch;
		@(posedge clk) disable iff (!nrst)
		link.ctl_wr && wr_ptr == PTR_POKE_SWITCH && wr_page == PAGE_POKE_OFF
		##1 !link.ctl_wr |=> !link.poke_ok;
	endproperty
	a_poke_switch: assert property (p_poke_switch) else $error("write not disabled");

	property p_fail_flag;
		@(posedge clk) disable iff (!nrst)
		link.poke |=> link.status[STAT_POKE_BIT] == !$past(link.poke_ok);
	endproperty
	a_fail_flag: assert property (p_fail_flag) else $error("write failed flag wrong");
endmodule // indirect_host

// ---- logic/regbank_pkg.sv ----
// Shared command codes, field layouts, reset values and state types for the indirect register bank
package regbank_pkg;
	// ----------------------------------------------------------------
	// Command codes of the serial management port
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_PAGE = 8'h00;
	localparam logic [7:0] CMD_CHANNEL_MASK = 8'hd0;
	localparam logic [7:0] CMD_BASE_ADDRESS = 8'hd1;
	localparam logic [7:0] CMD_INDIRECT_CONTROL = 8'hd2;
	localparam logic [7:0] CMD_DATA_HOST_ZERO = 8'hd3;
	localparam logic [7:0] CMD_DATA_HOST_ONE = 8'hd4;
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [6:0] BASE_RESET = 7'h5c;
	localparam logic [7:0] MASK_RESET = 8'hff;
	localparam logic [7:0] PAGE_RESET = 8'h00;
	localparam logic [7:0] GLOBAL_PAGE = 8'hff;
	// ----------------------------------------------------------------
	// Indirect control word fields
	// ----------------------------------------------------------------
	localparam int CTL_HOST_BIT = 14;
	localparam int CTL_PAGE_LSB = 9;
	localparam int CTL_PAGE_MSB = 13;
	localparam int CTL_PTR_MSB = 8;
	localparam logic [15:0] CTL_READ_MASK = 16'h7fff;
	localparam logic [8:0] PTR_POKE_SWITCH = 9'h1f6;
	localparam logic [4:0] PAGE_POKE_ON = 5'h05;
	localparam logic [4:0] PAGE_POKE_OFF = 5'h00;
	localparam logic [4:0] LAST_PAGE = 5'h07;
	localparam logic [8:0] PTR_STATUS_ZERO = 9'h02c;
	localparam logic [8:0] PTR_STATUS_ONE = 9'h02d;
	localparam logic [8:0] PTR_BLOCK = 9'h0ee;
	localparam int STAT_POKE_BIT = 1;
	localparam int STAT_BLOCK_BIT = 0;
	localparam int HOSTS = 2;
	// ----------------------------------------------------------------
	// Address select pin levels
	// ----------------------------------------------------------------
	localparam logic [1:0] SEL_HIGH = 2'h2;
	localparam logic [3:0] OFFSET_MAX = 4'h8;
	typedef enum logic {ST_IDLE, ST_FETCH} read_state_type;
endpackage

// ---- logic/regbank_top.sv ----
// Page mask, bus address and indirect access register bank of the management port
// How it works
// - Mask bit n lets channel n follow global page writes; zero ignores them.
// - Bus address is programmed base plus pin-selected offset zero to eight.
// - Base resets to 0x5c; both select pins high give offset eight.
// - Base register holds seven bits; top bit reads zero.
// - Control word bit fifteen always reads zero.
// - Host-select bit of a control write picks which host caches it.
// - Five-bit page field cached per host; pokes only to pages zero to seven, peeks to any.
// - Nine-bit pointer cached per host selects the location reached.
// - Indirect accesses never disturb normal accesses or the standard page.
// - Block data can be read as successive word reads of data register.
// - Each extra host peeks any location using its own cached page.
// - Each extra host pokes via its cached page after setting the control word.
// - Control values 0x0bf6/0x01f6 and 0x4bf6/0x41f6 switch pokes on/off.
// - Pointer codes 0x2c and 0x2d give per-host status, peek only.
// - Data reads follow last control write; block reads past end give zeros.
// - Write failed flag sets on refused poke, clears on successful poke.
`timescale 1ns/1ns
module regbank_top import regbank_pkg::*; #(
	parameter int BLOCK_WORDS = 128
) (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic [6:0] CMD_ADDR,
	input wire logic CMD_WR,
	input wire logic CMD_RD,
	input wire logic [7:0] CMD_CODE,
	input wire logic [15:0] CMD_WDATA,
	input wire logic [1:0] ADDRESS_SELECT_HIGH,
	input wire logic [1:0] ADDRESS_SELECT_LOW,
	input wire logic BLOCK_ABORT,
	input wire logic [15:0] INT_RDATA,
	output logic [15:0] RDATA,
	output logic RVALID,
	output logic [6:0] BUS_ADDRESS,
	output logic [7:0] CHANNEL_GLOBAL_ENABLE,
	output logic [7:0] CHANNEL_SELECT,
	output logic INT_RD,
	output logic INT_WR,
	output logic INT_BLOCK,
	output logic [8:0] INT_POINTER,
	output logic [4:0] INT_PAGE,
	output logic [8:0] INT_INDEX,
	output logic [15:0] INT_WDATA
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	read_state_type state_reg, state_next;
	logic [7:0] page_reg, page_next;
	logic [7:0] global_page_channel_mask_reg, global_page_channel_mask_next;
	logic [6:0] base_reg, base_next;
	logic [15:0] ctl_reg, ctl_next;
	logic [6:0] addr_reg, addr_next;
	logic [7:0] sel_reg, sel_next;
	logic [15:0] hold_reg, hold_next;
	logic from_int_reg, from_int_next;
	logic [15:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic int_rd_reg, int_rd_next;
	logic int_wr_reg, int_wr_next;
	logic int_block_reg, int_block_next;
	logic [8:0] int_ptr_reg, int_ptr_next;
	logic [4:0] int_page_reg, int_page_next;
	logic [8:0] int_idx_reg, int_idx_next;
	logic [15:0] int_wdata_reg, int_wdata_next;

	logic [HOSTS-1:0] ctl_wr_h, poke_h, step_h, poke_ok_h;
	logic [8:0] ptr_h [HOSTS];
	logic [4:0] page_h [HOSTS];
	logic [8:0] idx_h [HOSTS];
	logic [15:0] status_h [HOSTS];
	logic hit, wr, rd, host_sel;
	logic [3:0] offset;

	// Three-level select pins: low, open, high
	function automatic logic [3:0] pin_level(input logic [1:0] s);
		return (s >= SEL_HIGH) ? 4'h2 : {2'h0, s};
	endfunction

	assign offset = 4'(pin_level(ADDRESS_SELECT_HIGH) * 4'h3 + pin_level(ADDRESS_SELECT_LOW));
	assign hit = CMD_ADDR == addr_reg;
	// Requests during a fetch are dropped so the cached pointer cannot move mid-read
	assign wr = CMD_WR && hit && state_reg == ST_IDLE;
	assign rd = CMD_RD && hit && !CMD_WR && state_reg == ST_IDLE;
	assign host_sel = CMD_CODE == CMD_DATA_HOST_ONE;

	// ----------------------------------------------------------------
	// Per-host contexts
	// ----------------------------------------------------------------
	for (genvar h = 0; h < HOSTS; h++) begin : g_host
		host_link_if link();
		indirect_host u_host (
			.clk(CLK),
			.nrst(NRST),
			.link(link.host)
		);
		assign link.ctl_wr = ctl_wr_h[h];
		assign link.ctl_data = CMD_WDATA;
		assign link.poke = poke_h[h];
		assign link.blk_step = step_h[h];
		assign link.blk_abort = BLOCK_ABORT;
		assign ptr_h[h] = link.ptr;
		assign page_h[h] = link.page;
		assign poke_ok_h[h] = link.poke_ok;
		assign idx_h[h] = link.blk_idx;
		assign status_h[h] = link.status;
	end

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		page_next = page_reg;
		global_page_channel_mask_next = global_page_channel_mask_reg;
		base_next = base_reg;
		ctl_next = ctl_reg;
		hold_next = hold_reg;
		from_int_next = from_int_reg;
		rdata_next = rdata_reg;
		rvalid_next = 1'b0;
		int_rd_next = 1'b0;
		int_wr_next = 1'b0;
		int_block_next = 1'b0;
		int_ptr_next = int_ptr_reg;
		int_page_next = int_page_reg;
		int_idx_next = int_idx_reg;
		int_wdata_next = int_wdata_reg;
		ctl_wr_h = '0;
		poke_h = '0;
		step_h = '0;
		addr_next = 7'(base_reg + {3'h0, offset});
		if (page_reg == GLOBAL_PAGE) begin
			sel_next = global_page_channel_mask_reg;
		end else if (page_reg <= {3'h0, LAST_PAGE}) begin
			sel_next = 8'h01 << page_reg[2:0];
		end else begin
			sel_next = 8'h00;
		end
		if (wr) begin
			case (CMD_CODE)
				CMD_PAGE: begin
					page_next = CMD_WDATA[7:0];
				end
				CMD_CHANNEL_MASK: begin
					global_page_channel_mask_next = CMD_WDATA[7:0];
				end
				CMD_BASE_ADDRESS: begin
					base_next = CMD_WDATA[6:0];
				end
				CMD_INDIRECT_CONTROL: begin
					ctl_next = CMD_WDATA & CTL_READ_MASK;
					ctl_wr_h[CMD_WDATA[CTL_HOST_BIT]] = 1'b1;
				end
				CMD_DATA_HOST_ZERO, CMD_DATA_HOST_ONE: begin
					poke_h[host_sel] = 1'b1;
					if (poke_ok_h[host_sel]) begin
						int_wr_next = 1'b1;
						int_ptr_next = ptr_h[host_sel];
						int_page_next = page_h[host_sel];
						int_wdata_next = CMD_WDATA;
					end
				end
				default: begin
				end
			endcase
		end
		case (state_reg)
			ST_IDLE: begin
				if (rd) begin
					state_next = ST_FETCH;
					from_int_next = 1'b0;
					hold_next = 16'h0000;
					case (CMD_CODE)
						CMD_PAGE: hold_next = {8'h00, page_reg};
						CMD_CHANNEL_MASK: hold_next = {8'h00, global_page_channel_mask_reg};
						CMD_BASE_ADDRESS: hold_next = {9'h000, base_reg};
						CMD_INDIRECT_CONTROL: hold_next = ctl_reg;
						CMD_DATA_HOST_ZERO, CMD_DATA_HOST_ONE: begin
							if (ptr_h[host_sel] == PTR_STATUS_ZERO) begin
								hold_next = status_h[0];
							end else if (ptr_h[host_sel] == PTR_STATUS_ONE) begin
								hold_next = status_h[1];
							end else if (ptr_h[host_sel] == PTR_BLOCK) begin
								step_h[host_sel] = 1'b1;
								if (idx_h[host_sel] < 9'(BLOCK_WORDS)) begin
									from_int_next = 1'b1;
									int_rd_next = 1'b1;
									int_block_next = 1'b1;
									int_ptr_next = PTR_BLOCK;
									int_idx_next = idx_h[host_sel];
								end
							end else begin
								from_int_next = 1'b1;
								int_rd_next = 1'b1;
								int_ptr_next = ptr_h[host_sel];
								int_page_next = page_h[host_sel];
							end
						end
						default: hold_next = 16'h0000;
					endcase
				end
			end
			ST_FETCH: begin
				state_next = ST_IDLE;
				rvalid_next = 1'b1;
				rdata_next = from_int_reg ? INT_RDATA : hold_reg;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			state_reg <= ST_IDLE;
			page_reg <= PAGE_RESET;
			global_page_channel_mask_reg <= MASK_RESET;
			base_reg <= BASE_RESET;
			ctl_reg <= 16'h0000;
			addr_reg <= BASE_RESET;
			sel_reg <= 8'h01;
			hold_reg <= 16'h0000;
			from_int_reg <= 1'b0;
			rdata_reg <= 16'h0000;
			rvalid_reg <= 1'b0;
			int_rd_reg <= 1'b0;
			int_wr_reg <= 1'b0;
			int_block_reg <= 1'b0;
			int_ptr_reg <= 9'h000;
			int_page_reg <= 5'h00;
			int_idx_reg <= 9'h000;
			int_wdata_reg <= 16'h0000;
		end else begin
			state_reg <= state_next;
			page_reg <= page_next;
			global_page_channel_mask_reg <= global_page_channel_mask_next;
			base_reg <= base_next;
			ctl_reg <= ctl_next;
			addr_reg <= addr_next;
			sel_reg <= sel_next;
			hold_reg <= hold_next;
			from_int_reg <= from_int_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
			int_rd_reg <= int_rd_next;
			int_wr_reg <= int_wr_next;
			int_block_reg <= int_block_next;
			int_ptr_reg <= int_ptr_next;
			int_page_reg <= int_page_next;
			int_idx_reg <= int_idx_next;
			int_wdata_reg <= int_wdata_next;
		end
	end

	assign RDATA = rdata_reg;
	assign RVALID = rvalid_reg;
	assign BUS_ADDRESS = addr_reg;
	assign CHANNEL_GLOBAL_ENABLE = global_page_channel_mask_reg;
	assign CHANNEL_SELECT = sel_reg;
	assign INT_RD = int_rd_reg;
	assign INT_WR = int_wr_reg;
	assign INT_BLOCK = int_block_reg;
	assign INT_POINTER = int_ptr_reg;
	assign INT_PAGE = int_page_reg;
	assign INT_INDEX = int_idx_reg;
	assign INT_WDATA = int_wdata_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_global_mask;
		@(posedge CLK) disable iff (!NRST)
		wr && CMD_CODE == CMD_CHANNEL_MASK && page_reg == GLOBAL_PAGE
		|=> ##1 CHANNEL_SELECT == $past(CMD_WDATA[7:0], 2);
	endproperty
	a_global_mask: assert property (p_global_mask) else $error("mask not applied");

	property p_address_match;
		@(posedge CLK) disable iff (!NRST)
		RVALID |-> $past(CMD_ADDR, 2) == $past(BUS_ADDRESS, 2);
	endproperty
	a_address_match: assert property (p_address_match) else $error("answered foreign address");

	property p_base_reset;
		@(posedge CLK) disable iff (!NRST)
		$rose(NRST) |-> base_reg == BASE_RESET;
	endproperty
	a_base_reset: assert property (p_base_reset) else $error("base reset wrong");

	property p_base_top_zero;
		@(posedge CLK) disable iff (!NRST)
		rd && CMD_CODE == CMD_BASE_ADDRESS |-> ##2 RVALID && RDATA[15:7] == 9'h000;
	endproperty
	a_base_top_zero: assert property (p_base_top_zero) else $error("base top bit set");

	property p_control_top_zero;
		@(posedge CLK) disable iff (!NRST)
		rd && CMD_CODE == CMD_INDIRECT_CONTROL |-> ##2 RVALID && !RDATA[15];
	endproperty
	a_control_top_zero: assert property (p_control_top_zero) else $error("bit 15 set");

	property p_other_host_kept;
		@(posedge CLK) disable iff (!NRST)
		wr && CMD_CODE == CMD_INDIRECT_CONTROL && CMD_WDATA[CTL_HOST_BIT]
		|=> ptr_h[0] == $past(ptr_h[0]) && page_reg == $past(page_reg);
	endproperty
	a_other_host_kept: assert property (p_other_host_kept) else $error("host zero disturbed");

	property p_poke_out;
		@(posedge CLK) disable iff (!NRST)
		wr && CMD_CODE == CMD_DATA_HOST_ZERO && poke_ok_h[0]
		|=> INT_WR && INT_POINTER == $past(ptr_h[0]) && INT_WDATA == $past(CMD_WDATA);
	endproperty
	a_poke_out: assert property (p_poke_out) else $error("write not issued");

	property p_bad_page_refused;
		@(posedge CLK) disable iff (!NRST)
		wr && CMD_CODE == CMD_DATA_HOST_ONE && page_h[1] > LAST_PAGE |=> !INT_WR;
	endproperty
	a_bad_page_refused: assert property (p_bad_page_refused) else $error("bad page written");

	property p_block_step;
		@(posedge CLK) disable iff (!NRST)
		rd && CMD_CODE == CMD_DATA_HOST_ZERO && ptr_h[0] == PTR_BLOCK
		&& idx_h[0] < 9'(BLOCK_WORDS) |=> INT_RD && INT_BLOCK && INT_INDEX == $past(idx_h[0]);
	endproperty
	a_block_step: assert property (p_block_step) else $error("block word not fetched");

	property p_block_end_zero;
		@(posedge CLK) disable iff (!NRST)
		rd && CMD_CODE == CMD_DATA_HOST_ZERO && ptr_h[0] == PTR_BLOCK
		&& idx_h[0] >= 9'(BLOCK_WORDS) |-> ##2 RVALID && RDATA == 16'h0000;
	endproperty
	a_block_end_zero: assert property (p_block_end_zero) else $error("data past end");

	property p_status_read;
		@(posedge CLK) disable iff (!NRST)
		rd && CMD_CODE == CMD_DATA_HOST_ONE && ptr_h[1] == PTR_STATUS_ONE
		|-> ##2 RVALID && RDATA[15:2] == 14'h0000;
	endproperty
	a_status_read: assert property (p_status_read) else $error("status word wrong");
endmodule // regbank_top

// ---- tb/int_mem_model.sv ----
// Behavioural model of the internal memory behind the indirect port
`timescale 1ns/1ns
module int_mem_model (
	input wire logic clk,
	input wire logic int_rd,
	input wire logic int_wr,
	input wire logic int_block,
	input wire logic [8:0] ptr,
	input wire logic [4:0] page,
	input wire logic [8:0] index,
	input wire logic [15:0] wdata,
	output logic [15:0] rdata
);
	logic hit_valid = 1'b0;
	logic [13:0] hit_key = 14'h0;
	logic [15:0] hit_data = 16'h0;
	logic tog = 1'b0;
	logic [15:0] word;
	// Last poke is remembered so that a later peek can see it
	always @(posedge clk) begin
		tog <= ~tog;
		if (int_wr) begin
			hit_valid <= 1'b1;
			hit_key <= {page, ptr};
			hit_data <= wdata;
		end
	end
	always_comb begin
		if (int_block)
			word = 16'hb000 + {7'h0, index};
		else if (hit_valid && hit_key == {page, ptr})
			word = hit_data;
		else
			word = {2'h0, page, ptr};
		// Outside a read the data churns so a stale sample cannot match
		rdata = int_rd ? word : ({16{tog}} ^ 16'h5a5a);
	end
endmodule // int_mem_model

// ---- tb/regbank_top_tb.sv ----
// Self-checking testbench of the page mask, bus address and indirect register bank
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module regbank_top_tb;
	import regbank_pkg::*;
	logic CLK = 1'b0, NRST = 1'b0, CMD_WR = 1'b0, CMD_RD = 1'b0, BLOCK_ABORT = 1'b0;
	logic [6:0] CMD_ADDR = 7'h0, BUS_ADDRESS, dev_addr = 7'h64;
	logic [7:0] CMD_CODE = 8'h0, CHANNEL_GLOBAL_ENABLE, CHANNEL_SELECT;
	logic [15:0] CMD_WDATA = 16'h0, INT_RDATA, RDATA, INT_WDATA, seen_wdata;
	logic [1:0] sel_high = 2'h2, sel_low = 2'h2;
	logic RVALID, INT_RD, INT_WR, INT_BLOCK, seen_wr;
	logic [8:0] INT_POINTER, INT_INDEX, seen_ptr;
	logic [4:0] INT_PAGE, seen_page;
	int miscompares = 0, n_checks = 0;
	always #25 CLK = ~CLK;
	regbank_top #(.BLOCK_WORDS(4)) i_dut (.CLK(CLK), .NRST(NRST), .CMD_ADDR(CMD_ADDR),
		.CMD_WR(CMD_WR), .CMD_RD(CMD_RD), .CMD_CODE(CMD_CODE), .CMD_WDATA(CMD_WDATA),
		.ADDRESS_SELECT_HIGH(sel_high), .ADDRESS_SELECT_LOW(sel_low),
		.BLOCK_ABORT(BLOCK_ABORT), .INT_RDATA(INT_RDATA), .RDATA(RDATA), .RVALID(RVALID),
		.BUS_ADDRESS(BUS_ADDRESS), .CHANNEL_GLOBAL_ENABLE(CHANNEL_GLOBAL_ENABLE),
		.CHANNEL_SELECT(CHANNEL_SELECT), .INT_RD(INT_RD), .INT_WR(INT_WR),
		.INT_BLOCK(INT_BLOCK), .INT_POINTER(INT_POINTER), .INT_PAGE(INT_PAGE),
		.INT_INDEX(INT_INDEX), .INT_WDATA(INT_WDATA));
	int_mem_model i_mem (.clk(CLK), .int_rd(INT_RD), .int_wr(INT_WR), .int_block(INT_BLOCK),
		.ptr(INT_POINTER), .page(INT_PAGE), .index(INT_INDEX), .wdata(INT_WDATA),
		.rdata(INT_RDATA));
	// ----------------------------------------------------------------
	// Port tasks, entered and left 1 ns after a rising edge
	// ----------------------------------------------------------------
	task automatic tick();
		@(posedge CLK);
		#1;
	endtask
	task automatic wr(input logic [7:0] code, input logic [15:0] d);
		CMD_ADDR = dev_addr;
		CMD_CODE = code;
		CMD_WDATA = d;
		CMD_WR = 1'b1;
		tick();
		CMD_WR = 1'b0;
		seen_wr = INT_WR;
		seen_ptr = INT_POINTER;
		seen_page = INT_PAGE;
		seen_wdata = INT_WDATA;
		// One idle edge so the next call never raises the strobe in this step
		tick();
	endtask
	task automatic chk_rd(input logic [7:0] code, input logic [15:0] e);
		int i;
		logic [15:0] d;
		d = 16'hxxxx;
		CMD_ADDR = dev_addr;
		CMD_CODE = code;
		CMD_RD = 1'b1;
		tick();
		CMD_RD = 1'b0;
		for (i = 0; i < 4; i++) begin
			tick();
			if (RVALID === 1'b1) begin
				d = RDATA;
				break;
			end
		end
		`CHK("read data", e, d)
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		int h, l, k;
		repeat (3) @(posedge CLK);
		#1 NRST = 1'b1;
		tick();
		tick();
		`CHK("bus address", 16'h0064, {9'h0, BUS_ADDRESS})
		`CHK("global enable", 16'h00ff, {8'h0, CHANNEL_GLOBAL_ENABLE})
		chk_rd(CMD_BASE_ADDRESS, 16'h005c);
		for (h = 0; h < 4; h++) begin
			for (l = 0; l < 4; l++) begin
				sel_high = h[1:0];
				sel_low = l[1:0];
				tick();
				tick();
				`CHK("bus address", {9'h0, 7'h5c + 7'(3 * (h > 1 ? 2 : h) + (l > 1 ? 2 : l))},
					{9'h0, BUS_ADDRESS})
			end
		end
		wr(CMD_BASE_ADDRESS, 16'h00a0);
		dev_addr = 7'h28;
		tick();
		`CHK("bus address", 16'h0028, {9'h0, BUS_ADDRESS})
		chk_rd(CMD_BASE_ADDRESS, 16'h0020);
		$display("address test done");
		wr(CMD_PAGE, 16'h00ff);
		wr(CMD_CHANNEL_MASK, 16'h00a5);
		dev_addr = 7'h5c;
		// Off-address write must leave the mask alone
		wr(CMD_CHANNEL_MASK, 16'h0000);
		dev_addr = 7'h28;
		tick();
		`CHK("channel select", 16'h00a5, {8'h0, CHANNEL_SELECT})
		`CHK("global enable", 16'h00a5, {8'h0, CHANNEL_GLOBAL_ENABLE})
		wr(CMD_PAGE, 16'h0009);
		tick();
		`CHK("channel select", 16'h0000, {8'h0, CHANNEL_SELECT})
		wr(CMD_PAGE, 16'h0002);
		tick();
		`CHK("channel select", 16'h0004, {8'h0, CHANNEL_SELECT})
		$display("mask test done");
		wr(CMD_INDIRECT_CONTROL, 16'h0879);
		wr(CMD_INDIRECT_CONTROL, 16'hcc21);
		chk_rd(CMD_INDIRECT_CONTROL, 16'h4c21);
		chk_rd(CMD_DATA_HOST_ZERO, 16'h0879);
		chk_rd(CMD_DATA_HOST_ONE, 16'h0c21);
		`CHK("channel select", 16'h0004, {8'h0, CHANNEL_SELECT})
		$display("peek test done");
		wr(CMD_INDIRECT_CONTROL, 16'h00ee);
		for (k = 0; k < 5; k++)
			chk_rd(CMD_DATA_HOST_ZERO, k < 4 ? 16'hb000 + 16'(k) : 16'h0000);
		BLOCK_ABORT = 1'b1;
		tick();
		BLOCK_ABORT = 1'b0;
		wr(CMD_INDIRECT_CONTROL, 16'h002c);
		chk_rd(CMD_DATA_HOST_ZERO, 16'h0001);
		$display("block test done");
		wr(CMD_INDIRECT_CONTROL, 16'h0879);
		wr(CMD_DATA_HOST_ZERO, 16'h1234);
		`CHK("poke strobe", 16'h0000, {15'h0, seen_wr})
		wr(CMD_INDIRECT_CONTROL, 16'h002c);
		chk_rd(CMD_DATA_HOST_ZERO, 16'h0003);
		wr(CMD_INDIRECT_CONTROL, 16'h0bf6);
		wr(CMD_INDIRECT_CONTROL, 16'h0879);
		wr(CMD_DATA_HOST_ZERO, 16'h1234);
		`CHK("poke strobe", 16'h0001, {15'h0, seen_wr})
		`CHK("poke target", 16'h0879, {2'h0, seen_page, seen_ptr})
		`CHK("poke data", 16'h1234, seen_wdata)
		chk_rd(CMD_DATA_HOST_ZERO, 16'h1234);
		wr(CMD_INDIRECT_CONTROL, 16'h002c);
		chk_rd(CMD_DATA_HOST_ZERO, 16'h0001);
		wr(CMD_INDIRECT_CONTROL, 16'h1279);
		wr(CMD_DATA_HOST_ZERO, 16'h4321);
		`CHK("poke strobe", 16'h0000, {15'h0, seen_wr})
		wr(CMD_INDIRECT_CONTROL, 16'h002c);
		chk_rd(CMD_DATA_HOST_ZERO, 16'h0003);
		wr(CMD_INDIRECT_CONTROL, 16'h4bf6);
		wr(CMD_INDIRECT_CONTROL, 16'h4210);
		wr(CMD_DATA_HOST_ONE, 16'h55aa);
		`CHK("poke strobe", 16'h0001, {15'h0, seen_wr})
		`CHK("poke target", 16'h0210, {2'h0, seen_page, seen_ptr})
		wr(CMD_INDIRECT_CONTROL, 16'h5210);
		wr(CMD_DATA_HOST_ONE, 16'h00ff);
		`CHK("poke strobe", 16'h0000, {15'h0, seen_wr})
		wr(CMD_INDIRECT_CONTROL, 16'h41f6);
		wr(CMD_DATA_HOST_ONE, 16'h0001);
		`CHK("poke strobe", 16'h0000, {15'h0, seen_wr})
		wr(CMD_INDIRECT_CONTROL, 16'h402d);
		chk_rd(CMD_DATA_HOST_ONE, 16'h0002);
		wr(CMD_INDIRECT_CONTROL, 16'h01f6);
		wr(CMD_INDIRECT_CONTROL, 16'h0879);
		wr(CMD_DATA_HOST_ZERO, 16'h0f0f);
		`CHK("poke strobe", 16'h0000, {15'h0, seen_wr})
		`CHK("channel select", 16'h0004, {8'h0, CHANNEL_SELECT})
		$display("poke test done");
		finish_test();
	end
	// Whole sequence needs under 150 cycles; the 3000-cycle limit leaves ample margin
	initial begin
		#(3000 * 50);
		miscompares++;
		finish_test();
	end
endmodule // regbank_top_tb
